// >>> core/fan_fault_guard.sv
// bridge fault guard: current limit, over-current retry and latch, thermal, undervoltage
// assumes gate requests and pwm timing come from logic on clk_in, fault flags from pins
`timescale 1ns/1ps
module fan_fault_guard #(
   parameter int DELAY_CYCLES   = fan_guard_pkg::ALL_OFF_DELAY_CYC,
   parameter int RESTART_CYCLES = fan_guard_pkg::OC_OFF_TIME_CYC,
   parameter int OC_BLANK       = fan_guard_pkg::OC_MASK_CYC,
   parameter int CL_BLANK       = fan_guard_pkg::CL_MASK_CYC,
   parameter int RETRY_LIMIT    = fan_guard_pkg::OC_RETRY_LIMIT
) (
   // clock and control
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   // from pwm and commutation logic, same clock
   input  wire logic [3:0] gate_req_in,
   input  wire logic       pwm_on_start_in,
   input  wire logic       speed_command_input_in,
   // comparator pins, asynchronous
   input  wire logic       current_sense_pin_in,
   input  wire logic [3:0] overcurrent_in,
   input  wire logic       temp_high_in,
   input  wire logic       temp_low_in,
   input  wire logic       motor_supply_low_in,
   input  wire logic       regulator_low_in,
   input  wire logic       motor_supply_ok_in,
   input  wire logic       regulator_ok_in,
   // bridge drive
   output logic [3:0]      gate_out,
   // status
   output logic            current_limit_out,
   output logic            overcurrent_shutdown_out,
   output logic            overcurrent_latched_out,
   output logic            thermal_shutdown_out,
   output logic            undervoltage_out,
   output logic [3:0]      retry_count_out
);

   // refuse values the sequencers cannot serve
   if (DELAY_CYCLES < 1 || RESTART_CYCLES <= DELAY_CYCLES) begin : g_chk_time
      $error("restart time must exceed the all-off delay");
   end
   if (RETRY_LIMIT < 1 || RETRY_LIMIT > 15) begin : g_chk_retry
      $error("retry limit must lie in 1..15");
   end

   // ---- pin conditioning ----
   logic [10:0] pin_lvl;       // synchronised pin levels
   logic       cl_raw;         // sense pin above limit
   logic [3:0] oc_raw;         // per transistor over-current
   logic       t_high;         // junction at upper threshold
   logic       t_low;          // junction at or below lower threshold
   logic       sup_low;        // either supply below lockout
   logic       sup_ok;         // both supplies recovered
   logic       cl_hit;         // current limit after masking
   logic [3:0] oc_hit;         // over-current after masking

   // all comparator pins share one synchroniser bank
   pin_sync #(
      .WIDTH    (11)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .ce_in    (ce_in),
      .pin_in   ({regulator_ok_in, motor_supply_ok_in, regulator_low_in, motor_supply_low_in,
                  temp_low_in, temp_high_in, overcurrent_in, current_sense_pin_in}),
      .level_out(pin_lvl)
   );

   assign cl_raw  = pin_lvl[0];
   assign oc_raw  = pin_lvl[4:1];
   assign t_high  = pin_lvl[5];
   assign t_low   = pin_lvl[6];
   assign sup_low = pin_lvl[7] | pin_lvl[8];
   assign sup_ok  = pin_lvl[9] & pin_lvl[10];  // motor and regulator both recovered

   // current-limit masking against noise spikes
   glitch_blank #(
      .WIDTH       (1),
      .BLANK_CYCLES(CL_BLANK)
   ) u_cl_blank (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .raw_in      (cl_raw),
      .hit_out     (cl_hit)
   );

   // per transistor over-current masking
   glitch_blank #(
      .WIDTH       (4),
      .BLANK_CYCLES(OC_BLANK)
   ) u_oc_blank (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .raw_in      (oc_raw),
      .hit_out     (oc_hit)
   );

   // ---- state ----
   logic                       cl_cut_ff;     // upper off until next pwm on
   fan_guard_pkg::oc_state_type oc_state_ff;  // over-current sequence
   logic [31:0]                oc_timer_ff;   // cycles since detection or clean run
   logic [3:0]                 oc_off_ff;     // transistors tripped individually
   logic [3:0]                 retry_ff;      // consecutive trips
   fan_guard_pkg::th_state_type th_state_ff;  // thermal sequence
   logic [31:0]                th_timer_ff;   // thermal pwm-off interval
   logic                       uvlo_ff;       // lockout active
   logic                       speed_prev_ff; // speed command last cycle
   logic [3:0]                 gate_ff;       // bridge drive
   logic                       th_act_ff;     // thermal status copy
   logic                       oc_act_ff;     // over-current status copy
   logic                       speed_rise;    // speed command reapplied
   logic                       oc_trip;       // fresh trip in idle
   logic [3:0]                 nxt_gate;      // bridge drive next

   assign speed_rise = speed_command_input_in & ~speed_prev_ff;
   assign oc_trip    = (oc_state_ff == fan_guard_pkg::OC_IDLE) && (|oc_hit);

   // speed command edge detector
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         speed_prev_ff <= 1'b1;  // an applied command at power-up is no reapply
      end else if (ce_in) begin
         speed_prev_ff <= speed_command_input_in;
      end
   end

   // current limit: cut upper until the next on-phase, a new hit wins
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cl_cut_ff <= 1'b0;
      end else if (ce_in) begin
         if (cl_hit) begin
            cl_cut_ff <= 1'b1;
         end else if (pwm_on_start_in) begin
            cl_cut_ff <= 1'b0;
         end
      end
   end

   // over-current sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         oc_state_ff <= fan_guard_pkg::OC_IDLE;
         oc_timer_ff <= fan_guard_pkg::TIMER_RST;
         oc_off_ff   <= fan_guard_pkg::GATE_RST;
         retry_ff    <= fan_guard_pkg::RETRY_RST;
      end else if (ce_in) begin
         unique case (oc_state_ff)
            // normal drive, count a clean run to forget old trips
            fan_guard_pkg::OC_IDLE: begin
               if (oc_trip) begin
                  oc_state_ff <= fan_guard_pkg::OC_SINGLE;
                  oc_timer_ff <= fan_guard_pkg::TIMER_RST;
                  oc_off_ff   <= oc_hit;
                  retry_ff    <= retry_ff + 4'h1;
               end else if (oc_timer_ff == 32'(RESTART_CYCLES - 1)) begin
                  retry_ff    <= fan_guard_pkg::RETRY_RST;
               end else begin
                  oc_timer_ff <= oc_timer_ff + 32'h1;
               end
            end
            // only the offending transistors off
            fan_guard_pkg::OC_SINGLE: begin
               oc_off_ff   <= oc_off_ff | oc_hit;
               oc_timer_ff <= oc_timer_ff + 32'h1;
               if (oc_timer_ff == 32'(DELAY_CYCLES - 1)) begin
                  oc_state_ff <= fan_guard_pkg::OC_ALL_OFF;
               end
            end
            // whole bridge off until the off timer runs out
            fan_guard_pkg::OC_ALL_OFF: begin
               oc_timer_ff <= oc_timer_ff + 32'h1;
               if (oc_timer_ff == 32'(RESTART_CYCLES - 1)) begin
                  oc_off_ff   <= fan_guard_pkg::GATE_RST;
                  oc_timer_ff <= fan_guard_pkg::TIMER_RST;
                  if (retry_ff >= 4'(RETRY_LIMIT)) begin
                     oc_state_ff <= fan_guard_pkg::OC_LATCHED;
                  end else begin
                     oc_state_ff <= fan_guard_pkg::OC_IDLE;
                  end
               end
            end
            // held off until speed reapplied or supply collapses
            fan_guard_pkg::OC_LATCHED: begin
               if (speed_rise || uvlo_ff) begin
                  oc_state_ff <= fan_guard_pkg::OC_IDLE;
                  retry_ff    <= fan_guard_pkg::RETRY_RST;
               end
            end
         endcase
      end
   end

   // thermal sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         th_state_ff <= fan_guard_pkg::TH_IDLE;
         th_timer_ff <= fan_guard_pkg::TIMER_RST;
      end else if (ce_in) begin
         unique case (th_state_ff)
            // watch for the upper threshold
            fan_guard_pkg::TH_IDLE: begin
               th_timer_ff <= fan_guard_pkg::TIMER_RST;
               if (t_high) begin
                  th_state_ff <= fan_guard_pkg::TH_PWM_OFF;
               end
            end
            // upper transistors off for the delay
            fan_guard_pkg::TH_PWM_OFF: begin
               th_timer_ff <= th_timer_ff + 32'h1;
               if (th_timer_ff == 32'(DELAY_CYCLES - 1)) begin
                  th_state_ff <= fan_guard_pkg::TH_ALL_OFF;
               end
            end
            // all off until cooled to the lower threshold
            fan_guard_pkg::TH_ALL_OFF: begin
               if (t_low && !t_high) begin
                  th_state_ff <= fan_guard_pkg::TH_IDLE;
               end
            end
         endcase
      end
   end

   // undervoltage lockout, a low flag wins over recovery
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         uvlo_ff <= fan_guard_pkg::UVLO_RST;
      end else if (ce_in) begin
         if (sup_low) begin
            uvlo_ff <= 1'b1;
         end else if (sup_ok) begin
            uvlo_ff <= 1'b0;
         end
      end
   end

   // combine every active fault, the strongest demand wins
   always_comb begin
      nxt_gate = gate_req_in;
      if (cl_hit || cl_cut_ff || th_state_ff == fan_guard_pkg::TH_PWM_OFF) begin
         nxt_gate = nxt_gate & ~fan_guard_pkg::UPPER_MASK;
      end
      nxt_gate = nxt_gate & ~oc_off_ff & ~(oc_trip ? oc_hit : 4'h0);
      if (uvlo_ff || sup_low
          || oc_state_ff == fan_guard_pkg::OC_ALL_OFF
          || oc_state_ff == fan_guard_pkg::OC_LATCHED
          || th_state_ff == fan_guard_pkg::TH_ALL_OFF) begin
         nxt_gate = 4'h0;
      end
   end

   // bridge drive and status registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gate_ff   <= fan_guard_pkg::GATE_RST;
         th_act_ff <= 1'b0;
         oc_act_ff <= 1'b0;
      end else if (ce_in) begin
         gate_ff   <= nxt_gate;
         th_act_ff <= (th_state_ff != fan_guard_pkg::TH_IDLE) || t_high;
         oc_act_ff <= (oc_state_ff != fan_guard_pkg::OC_IDLE) || oc_trip;
      end
   end

   assign gate_out                 = gate_ff;
   assign current_limit_out        = cl_cut_ff;
   assign overcurrent_shutdown_out = oc_act_ff;
   assign overcurrent_latched_out  = oc_state_ff[3];
   assign thermal_shutdown_out     = th_act_ff;
   assign undervoltage_out         = uvlo_ff;
   assign retry_count_out          = retry_ff;

   // ---- checks ----
   cl_upper_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      cl_hit |=> ((gate_ff & fan_guard_pkg::UPPER_MASK) == 4'h0))
      else $error("upper transistor still on during current limit");

   cl_resume_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (cl_cut_ff && pwm_on_start_in && !cl_hit) |=> !cl_cut_ff)
      else $error("current limit cut not released at pwm on");

   oc_first_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      oc_trip |=> ((gate_ff & $past(oc_hit)) == 4'h0) && oc_state_ff == fan_guard_pkg::OC_SINGLE)
      else $error("offending transistor not switched off");

   oc_all_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (oc_state_ff == fan_guard_pkg::OC_SINGLE && oc_timer_ff == 32'(DELAY_CYCLES - 1))
      |=> oc_state_ff == fan_guard_pkg::OC_ALL_OFF ##1 gate_ff == 4'h0)
      else $error("bridge not fully off after delay");

   oc_restart_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (oc_state_ff == fan_guard_pkg::OC_ALL_OFF && oc_timer_ff == 32'(RESTART_CYCLES - 1)
       && retry_ff < 4'(RETRY_LIMIT)) |=> oc_state_ff == fan_guard_pkg::OC_IDLE)
      else $error("no automatic restart after off time");

   oc_latch_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (oc_state_ff == fan_guard_pkg::OC_ALL_OFF && oc_timer_ff == 32'(RESTART_CYCLES - 1)
       && retry_ff >= 4'(RETRY_LIMIT)) |=> oc_state_ff == fan_guard_pkg::OC_LATCHED ##1 gate_ff == 4'h0)
      else $error("retry limit did not latch bridge off");

   latch_hold_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (oc_state_ff == fan_guard_pkg::OC_LATCHED && !speed_rise && !uvlo_ff)
      |=> oc_state_ff == fan_guard_pkg::OC_LATCHED)
      else $error("latched off state left without speed reapply");

   th_upper_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (th_state_ff == fan_guard_pkg::TH_PWM_OFF) |=> ((gate_ff & fan_guard_pkg::UPPER_MASK) == 4'h0))
      else $error("upper transistor on during thermal pwm-off");

   th_hold_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (th_state_ff == fan_guard_pkg::TH_ALL_OFF && !t_low) |=> th_state_ff == fan_guard_pkg::TH_ALL_OFF)
      else $error("thermal shutdown left above lower threshold");

   uvlo_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      sup_low |=> uvlo_ff && gate_ff == 4'h0)
      else $error("drive not forced off on low supply");

   uvlo_release_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (uvlo_ff && !sup_ok) |=> uvlo_ff)
      else $error("lockout released before both supplies recovered");

   th_entry_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (th_state_ff == fan_guard_pkg::TH_IDLE && t_high) |=> th_state_ff == fan_guard_pkg::TH_PWM_OFF)
      else $error("thermal shutdown not started on over-temperature");

   fault_all_off_a: assert property (
      @(posedge clk_in) disable iff (rst_in || !ce_in)
      (uvlo_ff || oc_state_ff == fan_guard_pkg::OC_LATCHED || th_state_ff == fan_guard_pkg::TH_ALL_OFF)
      |=> gate_ff == 4'h0)
      else $error("bridge driven while a fault demands all off");

endmodule

// >>> core/fan_guard_pkg.sv
// constants, timing figures and state codes shared by the bridge fault guard
// assumes a single 200 MHz clock and fault pins arriving from analog comparators
// Notes on behaviour
// - current limit acts at sense-pin threshold
// - current limit turns upper transistor off
// - drive resumes at next pwm on-phase
// - current-limit detect blanked against noise spikes
// - four separate over-current indications watched
// - offending transistor switched off first, immediately
// - all transistors off after fixed delay
// - off timer from detection, then auto restart
// - eighth consecutive trip latches all off
// - latch cleared by speed reapply or power
// - over-current pulses shorter than blanking ignored
// - thermal shutdown starts on over-temperature flag
// - thermal: upper off interval, then all off
// - thermal exit only at lower threshold
// - either supply low forces drive off
// - lockout released when both supplies recover
package fan_guard_pkg;

   // clock
   localparam int      CLK_PERIOD_PS     = 5000;          // 200 MHz
   // printed times, in their own units
   localparam int      ALL_OFF_DELAY_NS  = 1_000_000;     // 1 ms
   localparam int      OC_OFF_TIME_NS    = 100_000_000;   // 100 ms
   localparam int      OC_MASK_NS        = 2_000;         // 2 us
   localparam int      CL_MASK_NS        = 250;           // current-limit masking
   // cycle counts, least times rounded up
   localparam int      ALL_OFF_DELAY_CYC = int'((longint'(ALL_OFF_DELAY_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int      OC_OFF_TIME_CYC   = int'((longint'(OC_OFF_TIME_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int      OC_MASK_CYC       = int'((longint'(OC_MASK_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int      CL_MASK_CYC       = int'((longint'(CL_MASK_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   // trip count that latches the bridge off
   localparam int      OC_RETRY_LIMIT    = 8;
   // bridge layout: bit0 upper1, bit1 lower1, bit2 upper2, bit3 lower2
   localparam int      BRIDGE_W          = 4;
   localparam logic [3:0] UPPER_MASK     = 4'h5;
   localparam logic [3:0] ALL_MASK       = 4'hF;
   // values after reset
   localparam logic [3:0] GATE_RST       = 4'h0;
   localparam logic    UVLO_RST          = 1'b1;
   localparam logic [3:0] RETRY_RST      = 4'h0;
   localparam logic [31:0] TIMER_RST     = 32'h0;

   // over-current sequence
   typedef enum logic [3:0] {
      OC_IDLE    = 4'h1,
      OC_SINGLE  = 4'h2,
      OC_ALL_OFF = 4'h4,
      OC_LATCHED = 4'h8
   } oc_state_type;

   // thermal sequence
   typedef enum logic [2:0] {
      TH_IDLE    = 3'h1,
      TH_PWM_OFF = 3'h2,
      TH_ALL_OFF = 3'h4
   } th_state_type;

endpackage

// >>> core/glitch_blank.sv
// per-bit masking filter: a bit passes only after holding high long enough
// assumes inputs are already synchronous to clk_in
`timescale 1ns/1ps
module glitch_blank #(
   parameter int WIDTH        = 1,
   parameter int BLANK_CYCLES = 1
) (
   // clock and control
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   // raw levels
   input  wire logic [WIDTH-1:0] raw_in,
   // accepted levels
   output logic      [WIDTH-1:0] hit_out
);

   localparam int CW = $clog2(BLANK_CYCLES + 1);

   // refuse values the counter cannot serve
   if (WIDTH < 1 || BLANK_CYCLES < 1) begin : g_chk
      $error("glitch_blank needs width and blank cycles of at least one");
   end

   // one counter per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_ff;   // cycles held high so far
      logic          hit_ff;   // accepted high

      // count while high, drop at once when low
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            cnt_ff <= '0;
            hit_ff <= 1'b0;
         end else if (ce_in) begin
            if (!raw_in[i]) begin
               cnt_ff <= '0;
               hit_ff <= 1'b0;
            end else if (cnt_ff == CW'(BLANK_CYCLES - 1)) begin
               hit_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + CW'(1);
            end
         end
      end

      assign hit_out[i] = hit_ff;
   end

endmodule

// >>> core/pin_sync.sv
// three-stage synchroniser for comparator pins with agreement filter
// assumes pins are asynchronous to clk_in; outputs are clean levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and control
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_in,
   // filtered levels
   output logic      [WIDTH-1:0] level_out
);

   // refuse an empty vector
   if (WIDTH < 1) begin : g_chk
      $error("pin_sync width must be at least one");
   end

   logic [WIDTH-1:0] meta_ff;    // first stage, read only by second
   logic [WIDTH-1:0] sync_ff;    // second stage
   logic [WIDTH-1:0] hold_ff;    // third stage
   logic [WIDTH-1:0] level_ff;   // accepted level

   // shift chain
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_ff <= '0;
         sync_ff <= '0;
         hold_ff <= '0;
      end else if (ce_in) begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         hold_ff <= sync_ff;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         level_ff <= '0;
      end else if (ce_in) begin
         level_ff <= (sync_ff & hold_ff) | (level_ff & (sync_ff | hold_ff));
      end
   end

   assign level_out = level_ff;

endmodule

// >>> verif/fan_fault_source.sv
// bridge and analog comparators seen from the fault guard
// assumes levels are set by the bench; pins follow at once
`timescale 1ns/1ps
module fan_fault_source (
   // gates and commanded conditions
   input  wire logic [3:0]  gate_in,
   input  wire logic [3:0]  short_in,
   input  wire logic [15:0] sense_mv_in,
   input  wire logic [15:0] temp_c_in,
   input  wire logic [15:0] motor_mv_in,
   input  wire logic [15:0] reg_mv_in,
   // comparator pins
   output logic             sense_hit_out,
   output logic [3:0]       overcurrent_out,
   output logic             temp_high_out,
   output logic             temp_low_out,
   output logic             motor_low_out,
   output logic             reg_low_out,
   output logic             motor_ok_out,
   output logic             reg_ok_out
);
   // thresholds: mV and degrees
   localparam logic [15:0] CL_MV = 16'h012C;
   localparam logic [15:0] HI_C  = 16'h00AA;
   localparam logic [15:0] LO_C  = 16'h0082;
   localparam logic [15:0] LO_MV = 16'h0B54;
   localparam logic [15:0] OK_MV = 16'h0C80;
   // sense resistor voltage against limit
   assign sense_hit_out   = sense_mv_in >= CL_MV;
   // fault current only flows in a shorted transistor that is on
   assign overcurrent_out = short_in & gate_in;
   // two temperature thresholds give hysteresis
   assign temp_high_out   = temp_c_in >= HI_C;
   assign temp_low_out    = temp_c_in <= LO_C;
   // supply monitors
   assign motor_low_out   = motor_mv_in <= LO_MV;
   assign reg_low_out     = reg_mv_in <= LO_MV;
   assign motor_ok_out    = motor_mv_in >= OK_MV;
   assign reg_ok_out      = reg_mv_in >= OK_MV;
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the bridge fault guard
// assumes shortened counts; inputs driven at falling edges
`timescale 1ns/1ps
module tb_top;
   localparam int DLY = 20;
   // clock, reset and controls
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        pwm_on = 1'b0;
   logic        ce     = 1'b1;
   logic        speed  = 1'b1;
   logic [3:0]  short  = 4'h0;
   logic [15:0] sense  = 16'h0000;
   logic [15:0] temp   = 16'h0019;
   logic [15:0] motor  = 16'h0000;
   logic [15:0] regv   = 16'h0000;
   // pins and outputs
   logic        hit, t_hi, t_lo, m_lo, r_lo, m_ok, r_ok;
   logic [3:0]  oc, gate, retry;
   logic        cl, ocs, latched, ths, uv;
   int          fails = 0;
   int          compares = 0;
   int          n;
   always #2.5 clk_in = ~clk_in;
   fan_fault_source src (.gate_in(gate), .short_in(short), .sense_mv_in(sense), .temp_c_in(temp),
      .motor_mv_in(motor), .reg_mv_in(regv), .sense_hit_out(hit), .overcurrent_out(oc),
      .temp_high_out(t_hi), .temp_low_out(t_lo), .motor_low_out(m_lo), .reg_low_out(r_lo),
      .motor_ok_out(m_ok), .reg_ok_out(r_ok));
   fan_fault_guard #(.DELAY_CYCLES(DLY), .RESTART_CYCLES(100), .OC_BLANK(4), .CL_BLANK(3),
      .RETRY_LIMIT(8)) uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .gate_req_in(4'h9),
      .pwm_on_start_in(pwm_on), .speed_command_input_in(speed), .current_sense_pin_in(hit),
      .overcurrent_in(oc), .temp_high_in(t_hi), .temp_low_in(t_lo), .motor_supply_low_in(m_lo),
      .regulator_low_in(r_lo), .motor_supply_ok_in(m_ok), .regulator_ok_in(r_ok), .gate_out(gate),
      .current_limit_out(cl), .overcurrent_shutdown_out(ocs), .overcurrent_latched_out(latched),
      .thermal_shutdown_out(ths), .undervoltage_out(uv), .retry_count_out(retry));
   // compare one value and count it
   task automatic chk(input logic [3:0] exp, input logic [3:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task automatic pulse_pwm();
      pwm_on = 1'b1;
      cyc(1);
      pwm_on = 1'b0;
   endtask
   // lockout from reset, released when both supplies recover
   task automatic t_power();
      chk(4'h1, {3'h0, uv});
      motor = 16'h0CE4;
      regv = 16'h0CE4;
      for (n = 0; n < 30 && gate !== 4'h9; n++) cyc(1);
      chk(4'h9, gate);
      $display("test power done");
   endtask
   // current limit cut, blanking and resume at pwm on
   task automatic t_climit();
      sense = 16'h015E;
      for (n = 0; n < 20 && cl !== 1'b1; n++) cyc(1);
      cyc(1);
      chk(4'h8, gate);
      sense = 16'h0000;
      cyc(10);
      chk(4'h8, gate);
      ce = 1'b0;
      pulse_pwm();
      cyc(2);
      chk(4'h8, gate);
      ce = 1'b1;
      pulse_pwm();
      cyc(3);
      chk(4'h9, gate);
      sense = 16'h015E;
      cyc(2);
      sense = 16'h0000;
      cyc(10);
      chk(4'h0, {3'h0, cl});
      short = 4'h8;
      cyc(3);
      short = 4'h0;
      cyc(15);
      chk(4'h0, {3'h0, ocs});
      $display("test climit done");
   endtask
   // over-current trip, all-off delay, retries, latch and clear
   task automatic t_oc();
      short = 4'h8;
      for (n = 0; n < 30 && ocs !== 1'b1; n++) cyc(1);
      chk(4'h1, gate);
      chk(4'h1, retry);
      for (n = 0; n < 40 && gate !== 4'h0; n++) cyc(1);
      chk(4'h1, {3'h0, n >= DLY - 3 && n <= DLY + 3});
      for (n = 0; n < 200 && ocs !== 1'b0; n++) cyc(1);
      chk(4'h9, gate);
      for (n = 0; n < 30 && ocs !== 1'b1; n++) cyc(1);
      chk(4'h2, retry);
      for (n = 0; n < 3000 && latched !== 1'b1; n++) cyc(1);
      chk(4'h8, retry);
      short = 4'h0;
      cyc(300);
      chk(4'h0, gate);
      speed = 1'b0;
      cyc(3);
      speed = 1'b1;
      for (n = 0; n < 30 && gate !== 4'h9; n++) cyc(1);
      chk(4'h9, gate);
      chk(4'h0, {3'h0, latched});
      $display("test overcurrent done");
   endtask
   // thermal: upper off first, all off, hysteresis on exit
   task automatic t_thermal();
      temp = 16'h00AF;
      for (n = 0; n < 20 && ths !== 1'b1; n++) cyc(1);
      cyc(1);
      chk(4'h8, gate);
      for (n = 0; n < 40 && gate !== 4'h0; n++) cyc(1);
      chk(4'h1, {3'h0, n >= DLY - 4 && n <= DLY + 3});
      temp = 16'h0096;
      cyc(30);
      chk(4'h0, gate);
      temp = 16'h007D;
      for (n = 0; n < 20 && gate !== 4'h9; n++) cyc(1);
      chk(4'h9, gate);
      $display("test thermal done");
   endtask
   // undervoltage, partial recovery, overlap with thermal
   task automatic t_uvlo();
      regv = 16'h0AF0;
      cyc(10);
      chk(4'h0, gate);
      regv = 16'h0BB8;
      cyc(20);
      chk(4'h1, {3'h0, uv});
      temp = 16'h00AF;
      regv = 16'h0CE4;
      cyc(DLY + 20);
      chk(4'h0, {3'h0, uv});
      chk(4'h0, gate);
      temp = 16'h007D;
      for (n = 0; n < 20 && gate !== 4'h9; n++) cyc(1);
      chk(4'h9, gate);
      $display("test uvlo done");
   endtask
   task automatic wrap_up();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(20);
      rst_in = 1'b0;
      cyc(2);
      t_power();
      t_climit();
      t_oc();
      t_thermal();
      t_uvlo();
      wrap_up();
   end
   // watchdog well past the expected run
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      wrap_up();
   end
endmodule
